// ### logic/iep_pkg.sv
package iep_pkg;
   // register indices; byte address on the bus is four times the index
   localparam logic [7:0] IDX_EXT_ENABLE   = 8'hA3;
   localparam logic [7:0] IDX_EXT_FLAGS    = 8'hA4;
   localparam logic [7:0] IDX_EXT_TYPE     = 8'hA5;
   localparam logic [7:0] IDX_EXT_SENSE    = 8'hA6;
   localparam logic [7:0] IDX_EXT_DUAL     = 8'hA7;
   localparam logic [7:0] IDX_GATE_TWO     = 8'hAA;
   localparam logic [7:0] IDX_GATE_THREE   = 8'hAB;
   localparam logic [7:0] IDX_GATE_FOUR    = 8'hAC;
   localparam logic [7:0] IDX_GATE_FIVE    = 8'hAD;
   localparam logic [7:0] IDX_LEVEL_LOW    = 8'hB8;
   localparam logic [7:0] IDX_LEVEL_HIGH   = 8'hF8;
   localparam logic [7:0] IDX_EVT_STATUS   = 8'hC0;
   localparam logic [7:0] IDX_EVT_CLEAR    = 8'hC1;
   localparam logic [7:0] IDX_EVT_IRQ_EN   = 8'hC2;

   localparam int ADDR_W   = 10;
   localparam int DATA_W   = 32;
   localparam int REG_W    = 8;
   localparam int EXT_N    = 8;
   localparam int GROUP_N  = 8;
   localparam int REQ_N    = 15;

   localparam logic [7:0] RESET_VAL       = 8'h00;
   // writable masks: bits 7:6 of the gate banks are read-only zero
   localparam logic [7:0] GATE_TWO_MASK   = 8'h3F;
   localparam logic [7:0] GATE_HI_MASK    = 8'h3F;

   // gate bank two fields
   localparam int TIMER_N       = 5;
   localparam int NVM_BIT       = 5;
   // gate bank three fields
   localparam int CONV_BIT      = 0;
   localparam int CMP_BIT       = 1;
   localparam int WT_BIT        = 2;
   localparam int WDT_BIT       = 3;
   localparam int BIT_TMR_BIT   = 4;
   // gate banks four and five fields
   localparam int EXT4_BIT      = 4;
   localparam int EXT5_BIT      = 5;
   localparam int EXT6_BIT      = 0;
   localparam int EXT7_BIT      = 1;

   // positions in the gated request vector, then the pin number behind each external request
   localparam int REQ_TIMER0    = 0;
   localparam int REQ_NVM       = 5;
   localparam int REQ_CONV      = 6;
   localparam int REQ_CMP       = 7;
   localparam int REQ_WT        = 8;
   localparam int REQ_WDT       = 9;
   localparam int REQ_BIT_TMR   = 10;
   localparam int REQ_EXT4      = 11;
   localparam int REQ_EXT5      = 12;
   localparam int REQ_EXT6      = 13;
   localparam int REQ_EXT7      = 14;
   localparam int EXT4_PIN      = 4;
   localparam int EXT5_PIN      = 5;
   localparam int EXT6_PIN      = 6;
   localparam int EXT7_PIN      = 7;
endpackage

// ### logic/iep_pin_if.sv
`timescale 1ns/1ps
// per-pin trigger settings and the detected event
interface iep_pin_if;
   logic enable;
   logic trig_type;
   logic trig_sense;
   logic dual_edge;
   logic event_hit;
   modport det (input enable, input trig_type, input trig_sense, input dual_edge,
                output event_hit);
   modport ctl (output enable, output trig_type, output trig_sense, output dual_edge,
                input event_hit);
endinterface

// ### logic/iep_pin_detect.sv
`timescale 1ns/1ps
// one external pin: synchroniser, history and trigger decode
module iep_pin_detect (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic pin,
   iep_pin_if.det    cfg
);
   logic sync1_r, sync1_nxt;
   logic sync2_r, sync2_nxt;
   logic prev_r, prev_nxt;
   logic [1:0] wake_r, wake_nxt;
   logic valid_r, valid_nxt;
   logic rise, fall, level_hit, edge_hit;

   // next values; valid rises only once prev holds a real pin sample, so a pin
   // that idles high gives no false edge against the reset value of prev
   always_comb begin
      sync1_nxt = pin;
      sync2_nxt = sync1_r;
      prev_nxt  = sync2_r;
      wake_nxt  = {wake_r[0], 1'b1};
      valid_nxt = wake_r[1];
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         prev_r  <= 1'b0;
         wake_r  <= 2'h0;
         valid_r <= 1'b0;
      end else begin
         sync1_r <= sync1_nxt;
         sync2_r <= sync2_nxt;
         prev_r  <= prev_nxt;
         wake_r  <= wake_nxt;
         valid_r <= valid_nxt;
      end
   end

   // trigger decode on synchronised samples only
   always_comb begin
      rise      = valid_r & sync2_r & ~prev_r;
      fall      = valid_r & ~sync2_r & prev_r;
      level_hit = cfg.trig_sense ? ~sync2_r : sync2_r;
      edge_hit  = cfg.trig_sense ? fall : rise;
      if (!cfg.enable) begin
         cfg.event_hit = 1'b0;
      end else if (cfg.dual_edge) begin
         cfg.event_hit = rise | fall;
      end else if (cfg.trig_type) begin
         cfg.event_hit = edge_hit;
      end else begin
         cfg.event_hit = level_hit;
      end
   end
endmodule // iep_pin_detect

// ### logic/iep_ctrl.sv
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module iep_ctrl (
   input  wire logic                  REF_CLK,
   input  wire logic                  RESETN,
   input  wire logic                  PSEL,
   input  wire logic                  PENABLE,
   input  wire logic                  PWRITE,
   input  wire logic [9:0]            PADDR,
   input  wire logic [31:0]           PWDATA,
   output logic      [31:0]           PRDATA,
   output logic                       PREADY,
   output logic                       PSLVERR,
   input  wire logic [4:0]            TIMER_REQ,
   input  wire logic                  NVM_REQ,
   input  wire logic                  CONV_REQ,
   input  wire logic                  CMP_REQ,
   input  wire logic                  WATCH_TIMER_REQ,
   input  wire logic                  WATCHDOG_REQ,
   input  wire logic                  INTERVAL_REQ,
   input  wire logic [7:0]            EXT_PIN,
   output logic      [14:0]           GATED_REQ,
   output logic      [15:0]           GROUP_LEVEL,
   output logic      [7:0]            EXT_FLAG,
   output logic                       IRQ
);
   // software visible state
   logic [7:0] ext_enable_r, ext_enable_nxt;
   logic [7:0] ext_flags_r, ext_flags_nxt;
   logic [7:0] ext_type_r, ext_type_nxt;
   logic [7:0] ext_sense_r, ext_sense_nxt;
   logic [7:0] ext_dual_r, ext_dual_nxt;
   logic [7:0] gate_two_r, gate_two_nxt;
   logic [7:0] gate_three_r, gate_three_nxt;
   logic [7:0] gate_four_r, gate_four_nxt;
   logic [7:0] gate_five_r, gate_five_nxt;
   logic [7:0] level_low_r, level_low_nxt;
   logic [7:0] level_high_r, level_high_nxt;
   logic [7:0] evt_status_r, evt_status_nxt;
   logic [7:0] evt_irq_en_r, evt_irq_en_nxt;
   // bus answer and outputs
   logic [31:0] prdata_r, prdata_nxt;
   logic        pready_r, pready_nxt;
   logic        pslverr_r, pslverr_nxt;
   logic [14:0] gated_r, gated_nxt;
   logic [15:0] level_r, level_nxt;
   logic        irq_r, irq_nxt;

   logic [7:0]  pin_event;
   logic [7:0]  idx;
   logic        addr_ok;
   logic        setup_ph;
   logic        wr_ph;
   logic [7:0]  wbyte;
   logic [7:0]  rbyte;
   logic        mapped;

   // one detector per pin, settings passed through the pin interface
   genvar g;
   generate
      for (g = 0; g < iep_pkg::EXT_N; g++) begin : g_pin
         iep_pin_if pif ();
         assign pif.enable     = ext_enable_r[g];
         assign pif.trig_type  = ext_type_r[g];
         assign pif.trig_sense = ext_sense_r[g];
         assign pif.dual_edge  = ext_dual_r[g];
         assign pin_event[g]   = pif.event_hit;
         iep_pin_detect u_det (
            .clk    (REF_CLK),
            .resetn (RESETN),
            .pin    (EXT_PIN[g]),
            .cfg    (pif.det)
         );
      end
   endgenerate

   // bus decode; unaligned or unknown index answers with an error
   always_comb begin
      idx      = PADDR[9:2];
      addr_ok  = (PADDR[1:0] == 2'b00);
      setup_ph = PSEL & ~PENABLE;
      wr_ph    = PSEL & PENABLE & pready_r & PWRITE & ~pslverr_r;
      wbyte    = PWDATA[7:0];
      mapped   = 1'b1;
      rbyte    = iep_pkg::RESET_VAL;
      case (idx)
         iep_pkg::IDX_EXT_ENABLE: rbyte = ext_enable_r;
         iep_pkg::IDX_EXT_FLAGS:  rbyte = ext_flags_r;
         iep_pkg::IDX_EXT_TYPE:   rbyte = ext_type_r;
         iep_pkg::IDX_EXT_SENSE:  rbyte = ext_sense_r;
         iep_pkg::IDX_EXT_DUAL:   rbyte = ext_dual_r;
         iep_pkg::IDX_GATE_TWO:   rbyte = gate_two_r;
         iep_pkg::IDX_GATE_THREE: rbyte = gate_three_r;
         iep_pkg::IDX_GATE_FOUR:  rbyte = gate_four_r;
         iep_pkg::IDX_GATE_FIVE:  rbyte = gate_five_r;
         iep_pkg::IDX_LEVEL_LOW:  rbyte = level_low_r;
         iep_pkg::IDX_LEVEL_HIGH: rbyte = level_high_r;
         iep_pkg::IDX_EVT_STATUS: rbyte = evt_status_r;
         iep_pkg::IDX_EVT_CLEAR:  rbyte = iep_pkg::RESET_VAL;  // write-only
         iep_pkg::IDX_EVT_IRQ_EN: rbyte = evt_irq_en_r;
         default:                 mapped = 1'b0;
      endcase
      if (!addr_ok) begin
         mapped = 1'b0;
      end
   end

   // answer is prepared in the setup cycle so every access has no wait state
   always_comb begin
      pready_nxt  = setup_ph;
      pslverr_nxt = setup_ph & ~mapped;
      prdata_nxt  = prdata_r;
      if (setup_ph) begin
         prdata_nxt = (mapped && !PWRITE) ? {24'h000000, rbyte} : 32'h00000000;
      end
   end

   // pin trigger settings, written by software only
   // the detectors see a new setting one cycle after the write
   always_comb begin
      ext_enable_nxt = ext_enable_r;
      ext_type_nxt   = ext_type_r;
      ext_sense_nxt  = ext_sense_r;
      ext_dual_nxt   = ext_dual_r;
      if (wr_ph) begin
         case (idx)
            iep_pkg::IDX_EXT_ENABLE: ext_enable_nxt = wbyte;
            iep_pkg::IDX_EXT_TYPE:   ext_type_nxt   = wbyte;
            iep_pkg::IDX_EXT_SENSE:  ext_sense_nxt  = wbyte;
            iep_pkg::IDX_EXT_DUAL:   ext_dual_nxt   = wbyte;
            default:                 ext_enable_nxt = ext_enable_r;
         endcase
      end
   end

   // pin trigger setting registers
   always_ff @(posedge REF_CLK) begin
      if (!RESETN) begin
         ext_enable_r <= iep_pkg::RESET_VAL;
         ext_type_r   <= iep_pkg::RESET_VAL;
         ext_sense_r  <= iep_pkg::RESET_VAL;
         ext_dual_r   <= iep_pkg::RESET_VAL;
      end else begin
         ext_enable_r <= ext_enable_nxt;
         ext_type_r   <= ext_type_nxt;
         ext_sense_r  <= ext_sense_nxt;
         ext_dual_r   <= ext_dual_nxt;
      end
   end

   // gate banks and group levels; bits 7:6 of the banks read as zero
   // reserved bits below bit 6 are kept so software reads back what it wrote there
   always_comb begin
      gate_two_nxt   = gate_two_r;
      gate_three_nxt = gate_three_r;
      gate_four_nxt  = gate_four_r;
      gate_five_nxt  = gate_five_r;
      level_low_nxt  = level_low_r;
      level_high_nxt = level_high_r;
      if (wr_ph) begin
         case (idx)
            iep_pkg::IDX_GATE_TWO:   gate_two_nxt   = wbyte & iep_pkg::GATE_TWO_MASK;
            iep_pkg::IDX_GATE_THREE: gate_three_nxt = wbyte & iep_pkg::GATE_HI_MASK;
            iep_pkg::IDX_GATE_FOUR:  gate_four_nxt  = wbyte & iep_pkg::GATE_HI_MASK;
            iep_pkg::IDX_GATE_FIVE:  gate_five_nxt  = wbyte & iep_pkg::GATE_HI_MASK;
            iep_pkg::IDX_LEVEL_LOW:  level_low_nxt  = wbyte;
            iep_pkg::IDX_LEVEL_HIGH: level_high_nxt = wbyte;
            default:                 gate_two_nxt   = gate_two_r;
         endcase
      end
   end

   // gate bank and level registers
   // a gate change shows on the request outputs one edge after the write lands
   always_ff @(posedge REF_CLK) begin
      if (!RESETN) begin
         gate_two_r   <= iep_pkg::RESET_VAL;
         gate_three_r <= iep_pkg::RESET_VAL;
         gate_four_r  <= iep_pkg::RESET_VAL;
         gate_five_r  <= iep_pkg::RESET_VAL;
         level_low_r  <= iep_pkg::RESET_VAL;
         level_high_r <= iep_pkg::RESET_VAL;
      end else begin
         gate_two_r   <= gate_two_nxt;
         gate_three_r <= gate_three_nxt;
         gate_four_r  <= gate_four_nxt;
         gate_five_r  <= gate_five_nxt;
         level_low_r  <= level_low_nxt;
         level_high_r <= level_high_nxt;
      end
   end

   // flags, event status and its irq enable
   // hardware sets are applied last so they win over a same-cycle clear
   always_comb begin
      ext_flags_nxt  = ext_flags_r;
      evt_status_nxt = evt_status_r;
      evt_irq_en_nxt = evt_irq_en_r;
      if (wr_ph) begin
         case (idx)
            iep_pkg::IDX_EXT_FLAGS:  ext_flags_nxt  = ext_flags_r & wbyte;
            iep_pkg::IDX_EVT_CLEAR:  evt_status_nxt = evt_status_r & ~wbyte;
            iep_pkg::IDX_EVT_IRQ_EN: evt_irq_en_nxt = wbyte;
            default:                 ext_flags_nxt  = ext_flags_r;
         endcase
      end
      ext_flags_nxt  = ext_flags_nxt | pin_event;
      evt_status_nxt = evt_status_nxt | pin_event;
   end

   // flag and status registers
   // a level-mode pin that stays active keeps re-setting its flag every cycle
   always_ff @(posedge REF_CLK) begin
      if (!RESETN) begin
         ext_flags_r  <= iep_pkg::RESET_VAL;
         evt_status_r <= iep_pkg::RESET_VAL;
         evt_irq_en_r <= iep_pkg::RESET_VAL;
      end else begin
         ext_flags_r  <= ext_flags_nxt;
         evt_status_r <= evt_status_nxt;
         evt_irq_en_r <= evt_irq_en_nxt;
      end
   end

   // gated requests towards the core and group levels
   always_comb begin
      gated_nxt = '0;
      for (int t = 0; t < iep_pkg::TIMER_N; t++) begin
         gated_nxt[iep_pkg::REQ_TIMER0 + t] = TIMER_REQ[t] & gate_two_r[t];
      end
      gated_nxt[iep_pkg::REQ_NVM]     = NVM_REQ & gate_two_r[iep_pkg::NVM_BIT];
      gated_nxt[iep_pkg::REQ_CONV]    = CONV_REQ & gate_three_r[iep_pkg::CONV_BIT];
      gated_nxt[iep_pkg::REQ_CMP]     = CMP_REQ & gate_three_r[iep_pkg::CMP_BIT];
      gated_nxt[iep_pkg::REQ_WT]      = WATCH_TIMER_REQ & gate_three_r[iep_pkg::WT_BIT];
      gated_nxt[iep_pkg::REQ_WDT]     = WATCHDOG_REQ & gate_three_r[iep_pkg::WDT_BIT];
      gated_nxt[iep_pkg::REQ_BIT_TMR] = INTERVAL_REQ & gate_three_r[iep_pkg::BIT_TMR_BIT];
      // only named bits reach a request; reserved bits feed nothing
      gated_nxt[iep_pkg::REQ_EXT4] = ext_flags_r[iep_pkg::EXT4_PIN]
                                     & gate_four_r[iep_pkg::EXT4_BIT];
      gated_nxt[iep_pkg::REQ_EXT5] = ext_flags_r[iep_pkg::EXT5_PIN]
                                     & gate_four_r[iep_pkg::EXT5_BIT];
      gated_nxt[iep_pkg::REQ_EXT6] = ext_flags_r[iep_pkg::EXT6_PIN]
                                     & gate_five_r[iep_pkg::EXT6_BIT];
      gated_nxt[iep_pkg::REQ_EXT7] = ext_flags_r[iep_pkg::EXT7_PIN]
                                     & gate_five_r[iep_pkg::EXT7_BIT];
      for (int k = 0; k < iep_pkg::GROUP_N; k++) begin
         level_nxt[2*k +: 2] = {level_high_r[k], level_low_r[k]};
      end
      irq_nxt = |(evt_status_nxt & evt_irq_en_nxt);
   end

   // bus answer registers; prdata holds its value until the next setup cycle
   always_ff @(posedge REF_CLK) begin
      if (!RESETN) begin
         prdata_r  <= 32'h00000000;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         prdata_r  <= prdata_nxt;
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   // output registers; gated and level ports lag one cycle, irq is built from the next status and enable values so it does not; every port glitch free
   always_ff @(posedge REF_CLK) begin
      if (!RESETN) begin
         gated_r <= 15'h0000;
         level_r <= 16'h0000;
         irq_r   <= 1'b0;
      end else begin
         gated_r <= gated_nxt;
         level_r <= level_nxt;
         irq_r   <= irq_nxt;
      end
   end

   // outputs straight from flip-flops
   assign PRDATA      = prdata_r;
   assign PREADY      = pready_r;
   assign PSLVERR     = pslverr_r;
   assign GATED_REQ   = gated_r;
   assign GROUP_LEVEL = level_r;
   assign EXT_FLAG    = ext_flags_r;
   assign IRQ         = irq_r;
endmodule // iep_ctrl

// ### tb/iep_ctrl_properties.sv
`timescale 1ns/1ps
// relations between bus, request and flag ports of the controller
module iep_ctrl_properties (
   input wire logic        REF_CLK,
   input wire logic        RESETN,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [9:0]  PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic [4:0]  TIMER_REQ,
   input wire logic        NVM_REQ,
   input wire logic        CONV_REQ,
   input wire logic        CMP_REQ,
   input wire logic        WATCH_TIMER_REQ,
   input wire logic        WATCHDOG_REQ,
   input wire logic        INTERVAL_REQ,
   input wire logic [14:0] GATED_REQ,
   input wire logic [7:0]  EXT_FLAG
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESETN);
   // zero wait states: the answer comes exactly one edge after setup
   chk_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY && PSEL && PENABLE)
      else $error("pready missing after setup");
   chk_ready_only_setup: assert property (PREADY |-> $past(PSEL && !PENABLE))
      else $error("pready without setup");
   chk_err_with_ready: assert property (PSLVERR |-> PREADY)
      else $error("pslverr outside access");
   chk_rdata_upper_zero: assert property (PREADY |-> PRDATA[31:8] == 24'h000000)
      else $error("read data upper bits set");
   // a gated request never rises without its source high one edge earlier
   chk_timer_gate: assert property ((GATED_REQ[4:0] & ~$past(TIMER_REQ)) == 5'h00)
      else $error("timer request passed without source");
   chk_nvm_gate: assert property (GATED_REQ[5] |-> $past(NVM_REQ))
      else $error("memory request passed without source");
   chk_periph_gate: assert property ((GATED_REQ[10:6] & ~$past({INTERVAL_REQ,
      WATCHDOG_REQ, WATCH_TIMER_REQ, CMP_REQ, CONV_REQ})) == 5'h00)
      else $error("peripheral request passed without source");
   chk_ext_gate: assert property ((GATED_REQ[14:11] & ~$past(EXT_FLAG[7:4])) == 4'h0)
      else $error("external request passed without flag");
   // a flag only drops right after a write access to the flag register
   chk_flag_sticky: assert property (($past(EXT_FLAG) & ~EXT_FLAG) != 8'h00 |->
      $past(PSEL && PENABLE && PWRITE && PADDR == {iep_pkg::IDX_EXT_FLAGS, 2'b00}))
      else $error("flag cleared without write");
endmodule // iep_ctrl_properties
bind iep_ctrl iep_ctrl_properties i_iep_ctrl_properties (.REF_CLK, .RESETN, .PSEL, .PENABLE,
   .PWRITE, .PADDR, .PRDATA, .PREADY, .PSLVERR, .TIMER_REQ, .NVM_REQ, .CONV_REQ, .CMP_REQ,
   .WATCH_TIMER_REQ, .WATCHDOG_REQ, .INTERVAL_REQ, .GATED_REQ, .EXT_FLAG);

// ### tb/iep_src_model.sv
`timescale 1ns/1ps
// request sources and pins; all change just after the edge like same-clock peripherals
module iep_src_model (
   input  wire logic        clk,
   input  wire logic [10:0] req_cmd,
   input  wire logic [7:0]  pin_cmd,
   output logic      [4:0]  timer_req,
   output logic             nvm_req,
   output logic      [4:0]  periph_req, // conv, comparator, watch timer, watchdog, interval
   output logic      [7:0]  ext_pin
);
   // requests are levels held until the bench withdraws them; the bench holds
   // reset long enough for the first edge to load quiet values
   always @(posedge clk) begin
      timer_req <= req_cmd[4:0];
      nvm_req <= req_cmd[5];
      periph_req <= req_cmd[10:6];
      ext_pin <= pin_cmd;
   end
endmodule // iep_src_model

// ### tb/tb_iep_ctrl.sv
`timescale 1ns/1ps
module tb_iep_ctrl;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [9:0]  paddr = 10'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [10:0] req_cmd = 11'h000;
   logic [7:0]  pin_cmd = 8'h00;
   logic [4:0]  timer_req;
   logic        nvm_req;
   logic [4:0]  periph_req;
   logic [7:0]  ext_pin;
   logic [14:0] gated_req;
   logic [15:0] group_level;
   logic [7:0]  ext_flag;
   logic        irq;
   logic [7:0]  rd;
   logic        er;
   int          err_count = 0;
   int          n_tests = 0;
   int          cyc = 0;

   iep_src_model i_iep_src_model (.clk(clk), .req_cmd(req_cmd), .pin_cmd(pin_cmd),
      .timer_req(timer_req), .nvm_req(nvm_req), .periph_req(periph_req), .ext_pin(ext_pin));
   iep_ctrl i_iep_ctrl (.REF_CLK(clk), .RESETN(rst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .TIMER_REQ(timer_req), .NVM_REQ(nvm_req), .CONV_REQ(periph_req[0]),
      .CMP_REQ(periph_req[1]), .WATCH_TIMER_REQ(periph_req[2]), .WATCHDOG_REQ(periph_req[3]),
      .INTERVAL_REQ(periph_req[4]), .EXT_PIN(ext_pin), .GATED_REQ(gated_req),
      .GROUP_LEVEL(group_level), .EXT_FLAG(ext_flag), .IRQ(irq));

   // 250 MHz clock
   initial forever #2 clk = ~clk;

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // one apb transfer; request held until pready is sampled high at a rising edge
   task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // values read here are those the slave drove before this edge
      while (pready !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      chk("pready", pready, 1'b1);
      rd = prdata[7:0];
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00);
      chk("read data", rd, exp);
   endtask

   task automatic t_reset();
      logic [7:0] idx [14] = '{8'hA3, 8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'hAA, 8'hAB, 8'hAC,
                               8'hAD, 8'hB8, 8'hF8, 8'hC0, 8'hC1, 8'hC2};
      chk("outputs", {gated_req, ext_flag, irq}, 32'h00000000);
      chk("group level", group_level, 32'h00000000);
      foreach (idx[i]) rchk(idx[i], 8'h00);
   endtask

   // unmapped index is refused and reads as zero
   task automatic t_bus_err();
      apb(1'b1, 8'h00, 8'hFF);
      chk("write error", er, 1'b1);
      apb(1'b0, 8'h00, 8'h00);
      chk("read error", {er, rd}, 9'h100);
   endtask

   task automatic t_gates();
      apb(1'b1, iep_pkg::IDX_GATE_TWO, 8'hFF);
      rchk(iep_pkg::IDX_GATE_TWO, 8'h3F);
      req_cmd <= 11'h7FF;
      repeat (3) @(posedge clk);
      chk("gated", gated_req[10:0], 11'h03F);
      apb(1'b1, iep_pkg::IDX_GATE_TWO, 8'h2A);
      apb(1'b1, iep_pkg::IDX_GATE_THREE, 8'hFF);
      rchk(iep_pkg::IDX_GATE_THREE, 8'h3F);
      chk("gated", gated_req[10:0], 11'h7EA);
      apb(1'b1, iep_pkg::IDX_GATE_THREE, 8'h15);
      repeat (2) @(posedge clk);
      chk("gated", gated_req[10:0], 11'h56A);
      req_cmd <= 11'h000;
   endtask

   // group k level is {high[k], low[k]}: 5A and 3C give 0,1,2,3,3,2,1,0 from group 0
   task automatic t_level();
      apb(1'b1, iep_pkg::IDX_LEVEL_LOW, 8'h5A);
      apb(1'b1, iep_pkg::IDX_LEVEL_HIGH, 8'h3C);
      repeat (2) @(posedge clk);
      chk("group level", group_level, 16'h1BE4);
      rchk(iep_pkg::IDX_LEVEL_HIGH, 8'h3C);
   endtask

   // pin4 rising edge, pin5 low level, pin6 dual edge, pin7 disabled
   task automatic t_ext();
      apb(1'b1, iep_pkg::IDX_EXT_TYPE, 8'h50);
      apb(1'b1, iep_pkg::IDX_EXT_SENSE, 8'h60);
      apb(1'b1, iep_pkg::IDX_EXT_DUAL, 8'h40);
      apb(1'b1, iep_pkg::IDX_GATE_FOUR, 8'h10);
      apb(1'b1, iep_pkg::IDX_GATE_FIVE, 8'h01);
      apb(1'b1, iep_pkg::IDX_EXT_ENABLE, 8'h70);
      repeat (6) @(posedge clk);
      chk("flags", ext_flag, 8'h20);
      pin_cmd <= 8'hF0;
      repeat (6) @(posedge clk);
      chk("flags", ext_flag, 8'h70);
      chk("ext gated", gated_req[14:11], 4'h5);
      apb(1'b1, iep_pkg::IDX_EXT_FLAGS, 8'h8F);
      repeat (6) @(posedge clk);
      chk("flags", ext_flag, 8'h00);
      pin_cmd <= 8'h00;
      repeat (6) @(posedge clk);
      chk("flags", ext_flag, 8'h60);
      apb(1'b1, iep_pkg::IDX_EXT_FLAGS, 8'h00);
      rchk(iep_pkg::IDX_EXT_FLAGS, 8'h20);
   endtask

   // level pin5 keeps its status set; pin4 edge raises, mask and clear drop irq
   task automatic t_irq();
      apb(1'b1, iep_pkg::IDX_EVT_CLEAR, 8'hFF);
      rchk(iep_pkg::IDX_EVT_STATUS, 8'h20);
      rchk(iep_pkg::IDX_EVT_CLEAR, 8'h00);
      apb(1'b1, iep_pkg::IDX_EVT_IRQ_EN, 8'h10);
      chk("irq", irq, 1'b0);
      pin_cmd <= 8'h10;
      repeat (6) @(posedge clk);
      chk("irq", irq, 1'b1);
      apb(1'b1, iep_pkg::IDX_EVT_IRQ_EN, 8'h00);
      repeat (2) @(posedge clk);
      chk("irq masked", irq, 1'b0);
      apb(1'b1, iep_pkg::IDX_EVT_IRQ_EN, 8'h10);
      repeat (2) @(posedge clk);
      chk("irq", irq, 1'b1);
      apb(1'b1, iep_pkg::IDX_EVT_CLEAR, 8'h10);
      repeat (2) @(posedge clk);
      chk("irq cleared", irq, 1'b0);
   endtask

   // pin7 falling edge and pin3 high level, the two decodes left unused above
   task automatic t_modes();
      apb(1'b1, iep_pkg::IDX_EXT_ENABLE, 8'h88);
      apb(1'b1, iep_pkg::IDX_EXT_TYPE, 8'h80);
      apb(1'b1, iep_pkg::IDX_EXT_SENSE, 8'h80);
      apb(1'b1, iep_pkg::IDX_GATE_FOUR, 8'h30);
      apb(1'b1, iep_pkg::IDX_GATE_FIVE, 8'h03);
      apb(1'b1, iep_pkg::IDX_EXT_FLAGS, 8'h00);
      rchk(iep_pkg::IDX_EXT_FLAGS, 8'h00);
      pin_cmd <= 8'h88;
      repeat (6) @(posedge clk);
      chk("flags", ext_flag, 8'h08);
      pin_cmd <= 8'h00;
      repeat (6) @(posedge clk);
      chk("flags", ext_flag, 8'h88);
      chk("ext gated", gated_req[14:11], 4'h8);
   endtask

   // hang guard, far above the few hundred cycles the sequence takes
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         finish_test();
      end
   end

   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_bus_err();
      t_gates();
      t_level();
      t_ext();
      t_irq();
      t_modes();
      finish_test();
   end
endmodule // tb_iep_ctrl
